// ---- inc/usc_params.svh ----
`ifndef USC_PARAMS_SVH
`define USC_PARAMS_SVH
`define USC_OFF_DATA   3'h0
`define USC_OFF_STAT   3'h1
`define USC_OFF_CTRL   3'h2
`define USC_OFF_SHARED 3'h3
`define USC_OFF_BAUDLO 3'h4
`define USC_OFF_IRQST  3'h5
`define USC_OFF_IRQMSK 3'h6
`define USC_OFF_FRAME  3'h7
`define USC_SEL_BIT    7
`define USC_C_RXIE     7
`define USC_C_TXIE     6
`define USC_C_EMIE     5
`define USC_C_RECEIVER_ON     4
`define USC_C_TRANSMITTER_ON     3
`define USC_C_CSZH     2
`define USC_C_RX9      1
`define USC_C_TX9      0
`define USC_F_SYNC     6
`define USC_F_PAREN    5
`define USC_F_PARODD   4
`define USC_F_STOP2    3
`define USC_F_POL      0
`define USC_S_TXDONE   6
`define USC_CTRL_RST   8'h00
`define USC_FRAME_RST  7'h06
`define USC_OS_NORMAL  5'h10
`define USC_OS_DOUBLE  5'h08
`endif

// ---- inc/usc_pkg.sv ----
package usc_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} usc_rx_state_type;
endpackage

// ---- verilog/usc_baud_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module usc_baud_gen #(
  parameter int W = 12
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] div,
  input  wire logic         reload,
  output logic              tick
);
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic         tick_q;
  logic         tick_d;

  // Reload restarts the prescaler at once
  always_comb
  begin
    tick_d = !reload && (count_q == '0);
    if (reload || count_q == '0)
      count_d = div;
    else
      count_d = count_q - {{(W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= '0;
      tick_q  <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      tick_q  <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule
`default_nettype wire

// ---- verilog/usc_core.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "usc_params.svh"
module usc_core #(
  parameter int BAUD_W = 12
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       global_irq_en,
  input  wire logic       rxd,
  output logic            rxd_claim,
  output logic            txd,
  output logic            txd_oe,
  output logic            sync_serial_clock,
  output logic            sync_serial_clock_oe,
  output logic            rx_done_irq,
  output logic            tx_done_irq,
  output logic            tx_empty_irq,
  output logic            irq
);
  logic [7:0]        ctrl_q, ctrl_d;
  logic [6:0]        frame_q, frame_d;
  logic [BAUD_W-1:0] baud_q, baud_d;
  logic              dbl_q, dbl_d;
  logic              mpf_q, mpf_d;
  logic [2:0]        ist_q, ist_d;
  logic [2:0]        msk_q, msk_d;
  logic [7:0]        rdata_q, rdata_d;
  logic              txb_full_q, txb_full_d;
  logic [8:0]        txb_q, txb_d;
  logic [12:0]       tx_sr_q, tx_sr_d;
  logic [3:0]        tx_left_q, tx_left_d;
  logic [4:0]        tx_os_q, tx_os_d;
  logic              tx_done_q, tx_done_d;
  logic              xck_q, xck_d;
  usc_pkg::usc_rx_state_type rx_st_q, rx_st_d;
  logic [4:0]        rx_os_q, rx_os_d;
  logic [3:0]        rx_cnt_q, rx_cnt_d;
  logic [11:0]       rx_bits_q, rx_bits_d;
  logic              rx_full_q, rx_full_d;
  logic [7:0]        rx_data_q, rx_data_d;
  logic              rx9_q, rx9_d;
  logic              fe_q, fe_d;
  logic              dor_q, dor_d;
  logic              pe_q, pe_d;
  logic              rxd_m_q, rxd_s_q;
  logic              bt, baud_reload, data_rd, data_wr, stat_wr;
  logic              sync_mode, par_en, par_odd, pol, tx_busy, live;
  logic              tx_step, rx_smp, xck_rise, xck_fall;
  logic              tx_done_ev, rx_store_ev, rx_err_ev, rx_fin, addr_bit, perr;
  logic [3:0]        nbits;
  logic [4:0]        os_div;
  logic [8:0]        dmask;

  // Frame with start bit, data, optional parity, then idle ones
  function automatic logic [12:0] tx_frame(input logic [8:0] d, input logic [3:0] n,
                                           input logic pen, input logic podd);
    logic [12:0] f;
    logic [8:0]  m;
    m = 9'h1FF >> (4'h9 - n);
    f = 13'h1FFF;
    f[9:1] = (d & m) | ~m;
    f[0] = 1'b0;
    if (pen)
      f[n + 4'h1] = (^(d & m)) ^ podd;
    return f;
  endfunction

  assign data_rd   = rd && addr == `USC_OFF_DATA;
  assign data_wr   = wr && addr == `USC_OFF_DATA;
  assign stat_wr   = wr && addr == `USC_OFF_STAT;
  assign baud_reload = wr && addr == `USC_OFF_BAUDLO;
  assign sync_mode = frame_q[`USC_F_SYNC];
  assign par_en    = frame_q[`USC_F_PAREN];
  assign par_odd   = frame_q[`USC_F_PARODD];
  assign pol       = frame_q[`USC_F_POL];
  assign tx_busy   = tx_left_q != 4'h0;
  always_comb
  begin
    unique case ({ctrl_q[`USC_C_CSZH], frame_q[2:1]})
      3'h0: nbits = 4'h5;
      3'h1: nbits = 4'h6;
      3'h2: nbits = 4'h7;
      3'h7: nbits = 4'h9;
      default: nbits = 4'h8;
    endcase
  end
  assign dmask = 9'h1FF >> (4'h9 - nbits);
  assign os_div = dbl_q ? `USC_OS_DOUBLE : `USC_OS_NORMAL;

  usc_baud_gen #(
    .W(BAUD_W)
  ) u_baud (
    .clk    (clk),
    .rst_n  (rst_n),
    .div    (baud_q),
    .reload (baud_reload),
    .tick   (bt)
  );

  // edge selection against the synchronous clock
  assign live     = txd_oe || ctrl_q[`USC_C_RECEIVER_ON];
  assign xck_rise = bt && sync_mode && live && !xck_q;
  assign xck_fall = bt && sync_mode && live && xck_q;
  assign xck_d    = xck_q ^ (bt && sync_mode && live);
  assign tx_step  = sync_mode ? (pol ? xck_fall : xck_rise)
                              : (bt && tx_os_q >= os_div - 5'h01);

  // Register file
  always_comb
  begin
    ctrl_d  = ctrl_q;
    frame_d = frame_q;
    baud_d  = baud_q;
    dbl_d   = dbl_q;
    mpf_d   = mpf_q;
    msk_d   = msk_q;
    ist_d   = ist_q;
    rdata_d = 8'h00;
    if (wr)
    begin
      case (addr)
        `USC_OFF_STAT:
        begin
          dbl_d = wdata[1];
          mpf_d = wdata[0];
        end
        `USC_OFF_CTRL:   ctrl_d = {wdata[7:2], 1'b0, wdata[0]};
        `USC_OFF_SHARED:
        begin
          if (wdata[`USC_SEL_BIT])
            frame_d = wdata[6:0];
          else
            baud_d[BAUD_W-1:8] = wdata[BAUD_W-9:0];
        end
        `USC_OFF_BAUDLO: baud_d[7:0] = wdata;
        `USC_OFF_IRQST:  ist_d = ist_q & ~wdata[2:0];
        `USC_OFF_IRQMSK: msk_d = wdata[2:0];
        default:         ;
      endcase
    end
    ist_d = ist_d | {rx_err_ev, tx_done_ev, rx_store_ev};
    if (rd)
    begin
      unique case (addr)
        `USC_OFF_DATA:   rdata_d = rx_data_q;
        `USC_OFF_STAT:   rdata_d = {rx_full_q, tx_done_q, !txb_full_q, fe_q, dor_q, pe_q,
                                    dbl_q, mpf_q};
        `USC_OFF_CTRL:   rdata_d = {ctrl_q[7:2], rx9_q, ctrl_q[0]};
        `USC_OFF_SHARED: rdata_d = {{(16-BAUD_W){1'b0}}, baud_q[BAUD_W-1:8]};
        `USC_OFF_BAUDLO: rdata_d = baud_q[7:0];
        `USC_OFF_IRQST:  rdata_d = {5'h00, ist_q};
        `USC_OFF_IRQMSK: rdata_d = {5'h00, msk_q};
        `USC_OFF_FRAME:  rdata_d = {1'b1, frame_q};
      endcase
    end
  end

  // Transmitter; filter bit has no effect here
  always_comb
  begin
    txb_full_d = txb_full_q;
    txb_d      = txb_q;
    tx_sr_d    = tx_sr_q;
    tx_left_d  = tx_left_q;
    tx_os_d    = tx_os_q;
    tx_done_ev = 1'b0;
    if (bt)
      tx_os_d = (tx_os_q >= os_div - 5'h01) ? 5'h00 : tx_os_q + 5'h01;
    // Speed change restarts the transmit bit timer so tx_os_q never overshoots the new divisor
    if (stat_wr)
      tx_os_d = 5'h00;
    if (tx_step)
    begin
      if (tx_left_q > 4'h1)
      begin
        tx_sr_d   = {1'b1, tx_sr_q[12:1]};
        tx_left_d = tx_left_q - 4'h1;
      end
      // pending data still goes out after disable
      else if (txb_full_q)
      begin
        tx_sr_d    = tx_frame(txb_q, nbits, par_en, par_odd);
        tx_left_d  = 4'h2 + nbits + {3'h0, par_en} + {3'h0, frame_q[`USC_F_STOP2]};
        txb_full_d = 1'b0;
      end
      else
      begin
        tx_done_ev = tx_left_q == 4'h1;
        tx_sr_d    = 13'h1FFF;
        tx_left_d  = 4'h0;
      end
    end
    if (data_wr && ctrl_q[`USC_C_TRANSMITTER_ON] && !txb_full_q)
    begin
      txb_d      = {ctrl_q[`USC_C_TX9], wdata};
      txb_full_d = 1'b1;
    end
    tx_done_d = (tx_done_q && !(stat_wr && wdata[`USC_S_TXDONE])) || tx_done_ev;
  end

  // Receiver
  always_comb
  begin
    rx_st_d     = rx_st_q;
    rx_os_d     = rx_os_q;
    rx_cnt_d    = rx_cnt_q;
    rx_bits_d   = rx_bits_q;
    rx_full_d   = rx_full_q && !data_rd;
    rx_data_d   = rx_data_q;
    rx9_d       = rx9_q;
    fe_d        = fe_q;
    pe_d        = pe_q;
    dor_d       = dor_q && !data_rd;
    rx_fin      = 1'b0;
    rx_store_ev = 1'b0;
    rx_err_ev   = 1'b0;
    addr_bit    = 1'b0;
    perr        = 1'b0;
    rx_smp      = sync_mode ? (pol ? xck_rise : xck_fall)
                            : (bt && rx_os_q >= os_div - 5'h01);
    if (bt)
      rx_os_d = rx_os_q + 5'h01;
    unique case (rx_st_q)
      usc_pkg::RX_IDLE:
      begin
        rx_os_d  = 5'h00;
        rx_cnt_d = 4'h0;
        if (!rxd_s_q && (!sync_mode || rx_smp))
          rx_st_d = sync_mode ? usc_pkg::RX_BITS : usc_pkg::RX_START;
      end
      usc_pkg::RX_START:
      begin
        if (bt && rx_os_q >= (os_div >> 1) - 5'h01)
        begin
          rx_os_d = 5'h00;
          rx_st_d = rxd_s_q ? usc_pkg::RX_IDLE : usc_pkg::RX_BITS;
        end
      end
      usc_pkg::RX_BITS:
      begin
        if (rx_smp)
        begin
          rx_os_d = 5'h00;
          rx_bits_d[rx_cnt_q] = rxd_s_q;
          rx_cnt_d = rx_cnt_q + 4'h1;
          if (rx_cnt_q == nbits + {3'h0, par_en})
          begin
            rx_st_d  = usc_pkg::RX_IDLE;
            rx_fin   = 1'b1;
            addr_bit = rx_bits_d[nbits - 4'h1];
            perr = par_en && ((^(rx_bits_d[8:0] & dmask)) ^ rx_bits_d[nbits] ^ par_odd);
            // with mpf_q set, drop frames without the address bit
            if (!mpf_q || addr_bit)
            begin
              if (!rx_full_q || data_rd)
              begin
                rx_data_d   = rx_bits_d[7:0] & dmask[7:0];
                rx9_d       = (nbits == 4'h9) && rx_bits_d[8];
                fe_d        = !rxd_s_q;
                pe_d        = perr;
                rx_full_d   = 1'b1;
                rx_store_ev = 1'b1;
                rx_err_ev   = !rxd_s_q || perr;
              end
              else
              begin
                dor_d     = 1'b1;
                rx_err_ev = 1'b1;
              end
            end
          end
        end
      end
    endcase
    if (!ctrl_q[`USC_C_RECEIVER_ON])
    begin
      rx_st_d   = usc_pkg::RX_IDLE;
      rx_full_d = 1'b0;
      fe_d      = 1'b0;
      dor_d     = 1'b0;
      pe_d      = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q     <= `USC_CTRL_RST;
      frame_q    <= `USC_FRAME_RST;
      baud_q     <= '0;
      dbl_q      <= 1'b0;
      mpf_q      <= 1'b0;
      ist_q      <= 3'h0;
      msk_q      <= 3'h0;
      rdata_q    <= 8'h00;
      txb_full_q <= 1'b0;
      txb_q      <= 9'h000;
      tx_sr_q    <= 13'h1FFF;
      tx_left_q  <= 4'h0;
      tx_os_q    <= 5'h00;
      tx_done_q  <= 1'b0;
      xck_q      <= 1'b0;
      rx_st_q    <= usc_pkg::RX_IDLE;
      rx_os_q    <= 5'h00;
      rx_cnt_q   <= 4'h0;
      rx_bits_q  <= 12'h000;
      rx_full_q  <= 1'b0;
      rx_data_q  <= 8'h00;
      rx9_q      <= 1'b0;
      fe_q       <= 1'b0;
      dor_q      <= 1'b0;
      pe_q       <= 1'b0;
      rxd_m_q    <= 1'b1;
      rxd_s_q    <= 1'b1;
    end
    else
    begin
      ctrl_q     <= ctrl_d;
      frame_q    <= frame_d;
      baud_q     <= baud_d;
      dbl_q      <= dbl_d;
      mpf_q      <= mpf_d;
      ist_q      <= ist_d;
      msk_q      <= msk_d;
      rdata_q    <= rdata_d;
      txb_full_q <= txb_full_d;
      txb_q      <= txb_d;
      tx_sr_q    <= tx_sr_d;
      tx_left_q  <= tx_left_d;
      tx_os_q    <= tx_os_d;
      tx_done_q  <= tx_done_d;
      xck_q      <= xck_d;
      rx_st_q    <= rx_st_d;
      rx_os_q    <= rx_os_d;
      rx_cnt_q   <= rx_cnt_d;
      rx_bits_q  <= rx_bits_d;
      rx_full_q  <= rx_full_d;
      rx_data_q  <= rx_data_d;
      rx9_q      <= rx9_d;
      fe_q       <= fe_d;
      dor_q      <= dor_d;
      pe_q       <= pe_d;
      rxd_m_q    <= rxd;
      rxd_s_q    <= rxd_m_q;
    end
  end

  assign rdata = rdata_q;
  assign rxd_claim = ctrl_q[`USC_C_RECEIVER_ON];
  assign txd_oe = ctrl_q[`USC_C_TRANSMITTER_ON] || tx_busy || txb_full_q;
  assign txd = tx_sr_q[0];
  assign sync_serial_clock    = xck_q;
  assign sync_serial_clock_oe = sync_mode;
  assign rx_done_irq  = ctrl_q[`USC_C_RXIE] && global_irq_en && rx_full_q;
  assign tx_done_irq  = ctrl_q[`USC_C_TXIE] && global_irq_en && tx_done_q;
  assign tx_empty_irq = ctrl_q[`USC_C_EMIE] && global_irq_en && !txb_full_q;
  assign irq = |(ist_q & msk_q);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_shared_sel;
    wr && addr == `USC_OFF_SHARED && !wdata[7] |=>
      baud_q[BAUD_W-1:8] == $past(wdata[BAUD_W-9:0]) && $stable(frame_q);
  endproperty
  a_shared_sel: assert property (p_shared_sel) else $error("shared write hit frame");
  property p_dbl;
    tx_step && !sync_mode |-> tx_os_q == (dbl_q ? 5'h07 : 5'h0F);
  endproperty
  a_dbl: assert property (p_dbl) else $error("wrong oversampling divisor");
  property p_mp_drop;
    rx_fin && mpf_q && !addr_bit && !data_rd |=> rx_full_q == $past(rx_full_q);
  endproperty
  a_mp_drop: assert property (p_mp_drop) else $error("data frame not filtered");
  property p_rx_irq;
    $rose(rx_full_q) && ctrl_q[7] && global_irq_en |-> rx_done_irq;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("receive request missing");
  property p_flush;
    $fell(ctrl_q[4]) |=> !rx_full_q && !fe_q && !dor_q && !pe_q;
  endproperty
  a_flush: assert property (p_flush) else $error("receiver not flushed");
  property p_drain;
    (tx_busy || txb_full_q) && !ctrl_q[3] |-> txd_oe;
  endproperty
  a_drain: assert property (p_drain) else $error("pin released early");
  property p_edge0;
    sync_mode && !pol && $changed(txd) |-> $rose(sync_serial_clock);
  endproperty
  a_edge0: assert property (p_edge0) else $error("data moved off rising edge");
  property p_edge1;
    sync_mode && pol && $changed(txd) |-> $fell(sync_serial_clock);
  endproperty
  a_edge1: assert property (p_edge1) else $error("data moved off falling edge");
  property p_rd_shared;
    rd && addr == `USC_OFF_SHARED |=> !rdata[7];
  endproperty
  a_rd_shared: assert property (p_rd_shared) else $error("select bit read as one");
  property p_ninth;
    rd && addr == `USC_OFF_CTRL |=> rdata[1] == $past(rx9_q);
  endproperty
  a_ninth: assert property (p_ninth) else $error("ninth bit misreported");
  c_rx_store: cover property (rx_store_ev);
  c_tx_done: cover property (tx_done_ev ##1 tx_done_irq);
  c_overrun: cover property ($rose(dor_q));
endmodule
`default_nettype wire

// ---- verification/usc_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module usc_peer (
  input  wire logic clk,
  input  wire logic sck,
  input  wire logic txd,
  output logic      rxd
);
  logic [8:0]  got;
  int unsigned start_clks;
  logic        lost;

  initial
  begin
    rxd = 1'b1;
    got = '0;
    start_clks = 0;
    lost = 1'b0;
  end

  // Async frame: start low, data LSB first, one stop high, line idles high
  task automatic send(input logic [8:0] v, input int n, input int bt);
    rxd <= 1'b0;
    repeat (bt) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      rxd <= v[i];
      repeat (bt) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (bt) @(posedge clk);
  endtask

  // Bit time is taken from the start bit, so data LSB must be one
  task automatic recv(input int n);
    int c;
    c = 0;
    got = '0;
    while (txd !== 1'b0 && c < 20000)
    begin
      @(posedge clk);
      #1;
      c++;
    end
    lost = (c >= 20000);
    start_clks = 0;
    while (txd === 1'b0 && start_clks < 1000)
    begin
      @(posedge clk);
      #1;
      start_clks++;
    end
    repeat (start_clks / 2) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      got[i] = txd;
      repeat (start_clks) @(posedge clk);
    end
  endtask

  // Sync frame: sample txd where sck moves to the level pol, start bit first
  task automatic recv_sync(input int n, input logic pol);
    int   c;
    int   i;
    logic prev;
    c = 0;
    i = -1;
    got = '0;
    prev = sck;
    while (i < n && c < 20000)
    begin
      @(posedge clk);
      #1;
      c++;
      if (prev !== sck && sck === pol)
      begin
        if (i >= 0)
        begin
          got[i] = txd;
          i++;
        end
        else if (txd === 1'b0)
          i = 0;
      end
      prev = sck;
    end
    lost = (c >= 20000);
  endtask
endmodule
`default_nettype wire

// ---- verification/usc_core_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "usc_params.svh"
module usc_core_bench;
  logic       clk;
  logic       rst_n;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       gie;
  logic       rxd;
  logic       rxd_claim;
  logic       txd;
  logic       txd_oe;
  logic       sck;
  logic       sck_oe;
  logic       rx_irq;
  logic       tx_irq;
  logic       em_irq;
  logic       irq;
  int         n_errors;
  int         n_checks;

  usc_core i_dut (
    .clk                  (clk),
    .rst_n                (rst_n),
    .addr                 (addr),
    .wdata                (wdata),
    .wr                   (wr),
    .rd                   (rd),
    .rdata                (rdata),
    .global_irq_en        (gie),
    .rxd                  (rxd),
    .rxd_claim            (rxd_claim),
    .txd                  (txd),
    .txd_oe               (txd_oe),
    .sync_serial_clock    (sck),
    .sync_serial_clock_oe (sck_oe),
    .rx_done_irq          (rx_irq),
    .tx_done_irq          (tx_irq),
    .tx_empty_irq         (em_irq),
    .irq                  (irq)
  );

  usc_peer i_peer (
    .clk (clk),
    .sck (sck),
    .txd (txd),
    .rxd (rxd)
  );

  always #5 clk = ~clk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp_val(input logic [8:0] g, input logic [8:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp_pin(input logic g, input logic e);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t pin got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata & m;
    n_checks++;
    if (v !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t reg %h got %h exp %h", $time, a, v, e);
    end
    @(posedge clk);
  endtask

  task automatic txchk(input logic [7:0] d, input int n, input logic [8:0] e,
                       input logic [8:0] bt);
    fork
      i_peer.recv(n);
      wreg(`USC_OFF_DATA, d);
    join
    cmp_pin(i_peer.lost, 1'b0);
    if (i_peer.lost)
      report_and_stop();
    else
    begin
      repeat (i_peer.start_clks + 4) @(posedge clk);
      cmp_val(i_peer.got, e);
      cmp_val(9'(i_peer.start_clks), bt);
    end
  endtask

  task automatic sync_tx(input logic [7:0] d, input logic pol, input logic [8:0] e);
    fork
      i_peer.recv_sync(8, pol);
      wreg(`USC_OFF_DATA, d);
    join
    cmp_pin(i_peer.lost, 1'b0);
    if (i_peer.lost)
      report_and_stop();
    else
    begin
      // Let the stop bit finish before any setting changes
      repeat (16) @(posedge clk);
      cmp_val(i_peer.got, e);
    end
  endtask

  task automatic rx_frame(input logic [8:0] v, input int n);
    i_peer.send(v, n, 32);
    repeat (8) @(posedge clk);
  endtask

  task automatic note(input string s);
    $display("test %0s done, mismatches %0d", s, n_errors);
  endtask

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    gie = 1'b0;
    n_errors = 0;
    n_checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    cmp_pin(txd, 1'b1);
    cmp_pin(txd_oe, 1'b0);
    cmp_pin(rxd_claim, 1'b0);
    rchk(`USC_OFF_CTRL, 8'hFF, `USC_CTRL_RST);
    rchk(`USC_OFF_FRAME, 8'hFF, 8'h86);
    rchk(`USC_OFF_STAT, 8'hFF, 8'h20);
    note("reset");
    wreg(`USC_OFF_SHARED, 8'h05);
    wreg(`USC_OFF_SHARED, 8'h8E);
    rchk(`USC_OFF_SHARED, 8'hFF, 8'h05);
    rchk(`USC_OFF_FRAME, 8'hFF, 8'h8E);
    wreg(`USC_OFF_SHARED, 8'h00);
    wreg(`USC_OFF_SHARED, 8'h86);
    wreg(`USC_OFF_BAUDLO, 8'h01);
    note("shared");
    wreg(`USC_OFF_CTRL, 8'h18);
    cmp_pin(rxd_claim, 1'b1);
    cmp_pin(txd_oe, 1'b1);
    txchk(8'hA5, 8, 9'h0A5, 9'h020);
    wreg(`USC_OFF_STAT, 8'h02);
    txchk(8'h3B, 8, 9'h03B, 9'h010);
    wreg(`USC_OFF_STAT, 8'h00);
    note("baud");
    wreg(`USC_OFF_CTRL, 8'h58);
    cmp_pin(tx_irq, 1'b0);
    gie <= 1'b1;
    @(posedge clk);
    cmp_pin(tx_irq, 1'b1);
    cmp_pin(em_irq, 1'b0);
    rchk(`USC_OFF_IRQST, 8'h02, 8'h02);
    wreg(`USC_OFF_IRQMSK, 8'h02);
    cmp_pin(irq, 1'b1);
    wreg(`USC_OFF_IRQMSK, 8'h00);
    cmp_pin(irq, 1'b0);
    wreg(`USC_OFF_IRQMSK, 8'h02);
    wreg(`USC_OFF_IRQST, 8'h02);
    cmp_pin(irq, 1'b0);
    wreg(`USC_OFF_STAT, 8'h40);
    cmp_pin(tx_irq, 1'b0);
    wreg(`USC_OFF_CTRL, 8'h38);
    cmp_pin(em_irq, 1'b1);
    gie <= 1'b0;
    @(posedge clk);
    cmp_pin(em_irq, 1'b0);
    gie <= 1'b1;
    note("irq");
    wreg(`USC_OFF_CTRL, 8'h18);
    fork
      i_peer.recv(8);
      begin
        wreg(`USC_OFF_DATA, 8'h81);
        wreg(`USC_OFF_CTRL, 8'h10);
        cmp_pin(txd_oe, 1'b1);
      end
    join
    cmp_val(i_peer.got, 9'h081);
    repeat (40) @(posedge clk);
    cmp_pin(txd_oe, 1'b0);
    cmp_pin(txd, 1'b1);
    note("drain");
    wreg(`USC_OFF_CTRL, 8'h98);
    rx_frame(9'h0A5, 8);
    cmp_pin(rx_irq, 1'b1);
    rchk(`USC_OFF_DATA, 8'hFF, 8'hA5);
    cmp_pin(rx_irq, 1'b0);
    wreg(`USC_OFF_STAT, 8'h01);
    rx_frame(9'h035, 8);
    rchk(`USC_OFF_STAT, 8'h80, 8'h00);
    rx_frame(9'h0B5, 8);
    rchk(`USC_OFF_DATA, 8'hFF, 8'hB5);
    txchk(8'h35, 8, 9'h035, 9'h020);
    wreg(`USC_OFF_STAT, 8'h00);
    note("receive");
    rx_frame(9'h011, 8);
    rx_frame(9'h022, 8);
    rchk(`USC_OFF_STAT, 8'h88, 8'h88);
    wreg(`USC_OFF_CTRL, 8'h08);
    rchk(`USC_OFF_STAT, 8'h9C, 8'h00);
    note("flush");
    wreg(`USC_OFF_CTRL, 8'h1C);
    rx_frame(9'h1C3, 9);
    rchk(`USC_OFF_CTRL, 8'h02, 8'h02);
    rchk(`USC_OFF_DATA, 8'hFF, 8'hC3);
    wreg(`USC_OFF_CTRL, 8'h1D);
    txchk(8'h5B, 9, 9'h15B, 9'h020);
    wreg(`USC_OFF_CTRL, 8'h18);
    wreg(`USC_OFF_SHARED, 8'h80);
    txchk(8'h01, 8, 9'h0E1, 9'h020);
    wreg(`USC_OFF_SHARED, 8'hA6);
    txchk(8'h83, 9, 9'h183, 9'h020);
    note("size");
    wreg(`USC_OFF_SHARED, 8'hC6);
    cmp_pin(sck_oe, 1'b1);
    sync_tx(8'h96, 1'b0, 9'h096);
    wreg(`USC_OFF_SHARED, 8'hC7);
    sync_tx(8'h69, 1'b1, 9'h069);
    note("sync");
    report_and_stop();
  end
endmodule
`default_nettype wire
